// ===== logic/i2c_arb_wake_ctl.sv
// Purpose: interrupt timing under arbitration, slave wakeup filter, start gating
// Assumes: byte shifting and stop generation live in a byte engine outside
// Notes:   the engine takes over the lines once the start sequence ends
// Notes on behaviour
// - arbitration or restart interrupts at byte clock
// - stop during arbitrated transfer interrupts if enabled
// - timing select one: interrupt on ninth fall
// - select zero, extension code: interrupt on eighth
// - line low on restart/stop attempt: byte interrupt
// - stop during restart attempt interrupts if enabled
// - slave interrupts only on match or extension
// - start enters wakeup standby through address
// - stop interrupt follows enable bit alone
// - reservation disabled: start request rejected while bus not ours
// - bus not ours: no role, or released
// - outcome flag shows generated or rejected start
// - outcome flag valid within five clocks
`timescale 1ns/1ps
`default_nettype none
module i2c_arb_wake_ctl
  import i2c_ctl_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       clock_line_pin,
  input  wire logic       sdaPin,
  input  wire logic       stop_irq_enable,
  input  wire logic       wait_irq_timing_select,
  input  wire logic       reservation_disable,
  input  wire logic       start_request,
  input  wire logic       bus_leave_release,
  input  wire logic       slaveEnable,
  input  wire logic [6:0] ownAddress,
  input  wire logic       arbLost,
  input  wire logic       checkRestart,
  input  wire logic       checkStop,
  output logic            bus_event_irq,
  output logic            start_outcome_flag,
  output logic            busBusy,
  output logic            masterMode,
  output logic            slaveMode,
  output logic            wakeupStandby,
  output logic            sdaOut,
  output logic            sdaOe_n,
  output logic            sclOut,
  output logic            sclOe_n
);

  localparam int FLAG_LIMIT = START_FLAG_MAX_CLK;

  lineEvents_t ev;
  genState_t   genState;
  genState_t   next_genState;
  logic [3:0]  bitCount;
  logic        skipFall;
  logic        addrPhase;
  logic [7:0]  addrShift;
  logic        arbLostHeld;
  logic [7:0]  genCount;

  line_monitor monitor (
    .clk            (clk),
    .reset_n        (reset_n),
    .clock_line_pin (clock_line_pin),
    .sdaPin         (sdaPin),
    .ev             (ev)
  );

  // byte position and address decode
  wire       countFall  = ev.sclFall & ~skipFall;
  wire [3:0] nextCount  = (bitCount == BIT_ACK_FALL) ? BIT_FIRST : 4'(bitCount + BIT_FIRST);
  wire [3:0] irqFall    = wait_irq_timing_select ? BIT_ACK_FALL : BIT_DATA_FALL;
  wire       addrDone   = addrPhase & countFall & (nextCount == BIT_DATA_FALL);
  wire       addrMatch  = (addrShift[7:1] == ownAddress);
  wire       extCode    = (addrShift[7:3] == EXT_CODE_LO) | (addrShift[7:3] == EXT_CODE_HI);
  wire       wakeHit    = addrDone & ((addrMatch & slaveEnable) | extCode);
  wire       involved   = masterMode | slaveMode | arbLostHeld | wakeHit;
  wire       byteIrq    = countFall & (nextCount == irqFall) & involved;
  wire       stopIrq    = ev.stop & stop_irq_enable;
  wire       collide    = ((checkRestart | checkStop) & ~ev.sdaHigh)
                          | (checkRestart & ~ev.sclHigh);
  wire       busNotOurs = busBusy & ~masterMode & ~slaveMode;
  wire       startReject = start_request & reservation_disable & busNotOurs;
  wire       startGo    = start_request & ~startReject & (genState == GEN_IDLE);
  wire       genDone    = (genCount == GEN_COUNT_ZERO);
  wire       enterScl   = (genState == GEN_SDA_LOW) & genDone;

  always_comb begin
    next_genState = genState;
    unique case (genState)
      GEN_IDLE: begin
        if (startGo) begin
          next_genState = busNotOurs ? GEN_WAIT_FREE : GEN_SDA_LOW;
        end
      end
      GEN_WAIT_FREE: begin
        if (!busBusy) begin
          next_genState = GEN_SDA_LOW;
        end
      end
      GEN_SDA_LOW: begin
        if (genDone) begin
          next_genState = GEN_SCL_LOW;
        end
      end
      GEN_SCL_LOW: begin
        if (genDone) begin
          next_genState = GEN_IDLE;
        end
      end
    endcase
  end

  // start sequence timing and line drive
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      genState <= GEN_IDLE;
      genCount <= GEN_COUNT_ZERO;
      sdaOe_n  <= 1'b1;
      sclOe_n  <= 1'b1;
      sdaOut   <= 1'b0;
      sclOut   <= 1'b0;
    end else begin
      genState <= next_genState;
      sdaOut   <= 1'b0;
      sclOut   <= 1'b0;
      if (next_genState == GEN_SDA_LOW && genState != GEN_SDA_LOW) begin
        genCount <= START_HOLD_COUNT;
      end else if (enterScl) begin
        genCount <= SCL_LOW_COUNT;
      end else if (!genDone) begin
        genCount <= genCount - 8'h01;
      end
      sdaOe_n <= (next_genState != GEN_SDA_LOW);
      sclOe_n <= (next_genState != GEN_SCL_LOW);
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      start_outcome_flag <= 1'b0;
    end else if (startReject) begin
      start_outcome_flag <= 1'b1;
    end else if (startGo) begin
      start_outcome_flag <= 1'b0;
    end
  end

  // byte counter and address capture
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      bitCount  <= BIT_ZERO;
      skipFall  <= 1'b0;
      addrPhase <= 1'b0;
      addrShift <= 8'h00;
    end else if (ev.start) begin
      bitCount  <= BIT_ZERO;
      skipFall  <= 1'b1;
      addrPhase <= 1'b1;
    end else begin
      if (ev.sclFall) begin
        skipFall <= 1'b0;
      end
      if (countFall) begin
        bitCount <= nextCount;
      end
      if (ev.sclRise && addrPhase) begin
        addrShift <= {addrShift[6:0], ev.sdaHigh};
      end
      if (addrDone || ev.stop) begin
        addrPhase <= 1'b0;
      end
    end
  end

  // bus roles and wakeup filter
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      busBusy       <= 1'b0;
      masterMode    <= 1'b0;
      slaveMode     <= 1'b0;
      wakeupStandby <= 1'b0;
      arbLostHeld   <= 1'b0;
      bus_event_irq <= 1'b0;
    end else begin
      bus_event_irq <= byteIrq | stopIrq;
      if (ev.start) begin
        busBusy <= 1'b1;
      end else if (ev.stop) begin
        busBusy <= 1'b0;
      end
      if (arbLost || collide || ev.stop) begin
        masterMode <= 1'b0;
      end else if (enterScl) begin
        masterMode <= 1'b1;
      end
      if (wakeHit) begin
        slaveMode <= 1'b1;
      end else if (ev.start || ev.stop || bus_leave_release) begin
        slaveMode <= 1'b0;
      end
      if (ev.start) begin
        wakeupStandby <= 1'b1;
      end else if (addrDone || ev.stop) begin
        wakeupStandby <= 1'b0;
      end
      if (arbLost || collide) begin
        arbLostHeld <= 1'b1;
      end else if (byteIrq || ev.stop) begin
        arbLostHeld <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_stop_irq_on: assert property (ev.stop && stop_irq_enable |=> bus_event_irq)
    else $error("stop with enable set gave no interrupt");
  chk_stop_irq_off: assert property (ev.stop && !stop_irq_enable && !byteIrq |=> !bus_event_irq)
    else $error("stop with enable clear gave an interrupt");
  chk_stop_restart: assert property (ev.stop && stop_irq_enable && arbLostHeld |=> bus_event_irq)
    else $error("stop during restart attempt missed interrupt");
  chk_reject_flag: assert property (startReject |-> ##[1:FLAG_LIMIT] start_outcome_flag)
    else $error("rejected start not flagged in time");
  chk_reject_no_drive: assert property (startReject && genState == GEN_IDLE |=> sdaOe_n [*3])
    else $error("rejected start drove the data line");
  chk_go_flag: assert property (startGo |=> !start_outcome_flag && $changed(genState))
    else $error("accepted start not reflected");
  chk_wake_enter: assert property (ev.start |=> wakeupStandby && addrPhase)
    else $error("start did not enter wakeup standby");
  chk_mismatch_quiet: assert property (addrDone && !wakeHit && !masterMode && !slaveMode && !arbLostHeld
                                       |=> !bus_event_irq)
    else $error("interrupt on address mismatch");
  chk_ninth_only: assert property (countFall && nextCount == BIT_DATA_FALL && wait_irq_timing_select
                                   && !ev.stop |=> !bus_event_irq)
    else $error("eighth-clock interrupt while ninth selected");
  chk_ext_eighth: assert property (addrDone && extCode && !wait_irq_timing_select |=> bus_event_irq)
    else $error("extension code missed eighth-clock interrupt");
  chk_arb_point: assert property (countFall && nextCount == irqFall && arbLostHeld |=> bus_event_irq)
    else $error("arbitration loss missed byte interrupt");
  chk_collide_lost: assert property (collide |=> arbLostHeld && !masterMode)
    else $error("line collision not treated as loss");

  cov_reject: cover property (startReject ##1 start_outcome_flag);
  cov_generate: cover property (startGo ##[1:300] !sdaOe_n);
  cov_wake: cover property (wakeHit ##1 slaveMode);
  cov_stop_irq: cover property (stopIrq ##1 bus_event_irq);

endmodule
`default_nettype wire

// ===== logic/i2c_ctl_pkg.sv
// Purpose: shared constants and types for the two-wire bus control block
// Assumes: clk at 25 MHz
// Notes:   start hold and clock low counts derive from times in ns and the clock period
package i2c_ctl_pkg;

  localparam int CLK_PERIOD_NS  = 40;
  localparam int START_HOLD_NS  = 4000;
  localparam int SCL_LOW_NS     = 4700;
  // least times round up to whole cycles
  localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_LOW_CYC    = (SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] START_HOLD_COUNT = 8'(START_HOLD_CYC - 1);
  localparam logic [7:0] SCL_LOW_COUNT    = 8'(SCL_LOW_CYC - 1);
  localparam logic [7:0] GEN_COUNT_ZERO   = 8'h00;

  // latest clock at which the start outcome flag is valid after a request
  localparam int START_FLAG_MAX_CLK = 5;

  // falling-edge numbers within a byte
  localparam logic [3:0] BIT_ZERO      = 4'h0;
  localparam logic [3:0] BIT_FIRST     = 4'h1;
  localparam logic [3:0] BIT_DATA_FALL = 4'h8;
  localparam logic [3:0] BIT_ACK_FALL  = 4'h9;

  // upper five bits of an address byte that carry an extension code
  localparam logic [4:0] EXT_CODE_LO = 5'h01;
  localparam logic [4:0] EXT_CODE_HI = 5'h1E;

  typedef struct packed {
    logic start;
    logic stop;
    logic sclFall;
    logic sclRise;
    logic sclHigh;
    logic sdaHigh;
  } lineEvents_t;

  typedef enum {GEN_IDLE, GEN_WAIT_FREE, GEN_SDA_LOW, GEN_SCL_LOW} genState_t;

endpackage

// ===== logic/line_monitor.sv
// Purpose: synchronise the bus lines and detect edges and conditions
// Assumes: lines are asynchronous to clk; link clock well below clk/2
// Notes:   events are combinational from the second sync stage onward
`timescale 1ns/1ps
`default_nettype none
module line_monitor
  import i2c_ctl_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset_n,
  input  wire logic  clock_line_pin,
  input  wire logic  sdaPin,
  output lineEvents_t ev
);

  logic sclMeta;
  logic sclSync;
  logic sclPrev;
  logic sdaMeta;
  logic sdaSync;
  logic sdaPrev;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclMeta <= 1'b1;
      sclSync <= 1'b1;
      sclPrev <= 1'b1;
      sdaMeta <= 1'b1;
      sdaSync <= 1'b1;
      sdaPrev <= 1'b1;
    end else begin
      sclMeta <= clock_line_pin;
      sclSync <= sclMeta;
      sclPrev <= sclSync;
      sdaMeta <= sdaPin;
      sdaSync <= sdaMeta;
      sdaPrev <= sdaSync;
    end
  end

  // start is data falling with clock high, stop is data rising with clock high
  assign ev.start   = sclSync & sclPrev & sdaPrev & ~sdaSync;
  assign ev.stop    = sclSync & sclPrev & ~sdaPrev & sdaSync;
  assign ev.sclFall = sclPrev & ~sclSync;
  assign ev.sclRise = ~sclPrev & sclSync;
  assign ev.sclHigh = sclSync;
  assign ev.sdaHigh = sdaSync;

endmodule
`default_nettype wire

// ===== dv/bus_partner.sv
// Purpose: another master on the two-wire bus, driving both lines open drain
// Assumes: 320 ns link clock, tasks started at a falling clk edge
// Notes:   a high output means released; the pull-up then holds the line
`timescale 1ns/1ps
`default_nettype none
module bus_partner (
  output logic sclRel,
  output logic sdaRel
);
  localparam time HALF = 160;
  initial begin
    sclRel = 1'b1;
    sdaRel = 1'b1;
  end
  task automatic start_cond();
    sdaRel = 1'b0;
    #HALF sclRel = 1'b0;
  endtask
  task automatic send_bit(input logic b);
    #(HALF / 2) sdaRel = b;
    #(HALF / 2) sclRel = 1'b1;
    #HALF sclRel = 1'b0;
  endtask
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      send_bit(b[i]);
    end
  endtask
  // data may only rise while the clock line is high to form a stop
  task automatic stop_cond();
    sclRel = 1'b0;
    #(HALF / 2) sdaRel = 1'b0;
    #(HALF / 2) sclRel = 1'b1;
    #HALF sdaRel = 1'b1;
    #HALF;
  endtask
endmodule
`default_nettype wire

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the arbitration, wakeup and start control
// Assumes: 25 MHz clk, partner model on the lines
// Notes:   interrupt pulses are counted per frame
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import i2c_ctl_pkg::*;
;
  logic clk, reset_n, stopEn, timSel, resvDis, startReq, leaveRel, slaveEn, arbLost, chkStop, chkRestart;
  logic [6:0] ownAddr;
  logic irq, flag, busBusy, masterMode, slaveMode, standby, sdaOut, sdaOe_n, sclOut, sclOe_n;
  logic sclRel, sdaRel;
  wire logic sclLine = sclRel & sclOe_n;
  wire logic sdaLine = sdaRel & sdaOe_n;
  int irqCount, n_errors, comparisons;
  bus_partner partner (.sclRel(sclRel), .sdaRel(sdaRel));
  i2c_arb_wake_ctl dut (.clk(clk), .reset_n(reset_n), .clock_line_pin(sclLine), .sdaPin(sdaLine),
    .stop_irq_enable(stopEn), .wait_irq_timing_select(timSel), .reservation_disable(resvDis),
    .start_request(startReq), .bus_leave_release(leaveRel), .slaveEnable(slaveEn),
    .ownAddress(ownAddr), .arbLost(arbLost), .checkRestart(chkRestart), .checkStop(chkStop),
    .bus_event_irq(irq), .start_outcome_flag(flag), .busBusy(busBusy), .masterMode(masterMode),
    .slaveMode(slaveMode), .wakeupStandby(standby), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n),
    .sclOut(sclOut), .sclOe_n(sclOe_n));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    if (irq === 1'b1) irqCount++;
  end
  task automatic check_bit(input string what, input logic exp, input logic got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic check_num(input string what, input int exp, input int got);
    comparisons++;
    if (got != exp) begin
      n_errors++;
      $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
    end
  endtask
  task automatic pulse(ref logic sig);
    sig = 1'b1;
    @(negedge clk) sig = 1'b0;
  endtask
  task automatic test_wakeup();
    logic [7:0] a [4] = '{8'hB4, 8'hB4, 8'h22, 8'hF0};
    logic s [4] = '{1'b0, 1'b1, 1'b0, 1'b0};
    int e8 [4] = '{1, 0, 0, 1};
    int e9 [4] = '{1, 1, 0, 1};
    for (int i = 0; i < 4; i++) begin
      timSel = s[i];
      stopEn = i[0];
      irqCount = 0;
      partner.start_cond();
      check_bit("standby", 1'b1, standby);
      partner.send_byte(a[i]);
      repeat (6) @(negedge clk);
      check_num("irq 8th", e8[i], irqCount);
      check_bit("standby end", 1'b0, standby);
      partner.send_bit(1'b1);
      repeat (6) @(negedge clk);
      check_num("irq 9th", e9[i], irqCount);
      check_bit("slave", e9[i] != 0, slaveMode);
      partner.stop_cond();
      repeat (4) @(negedge clk);
      check_num("stop irq", e9[i] + i[0], irqCount);
      check_bit("busy after stop", 1'b0, busBusy);
    end
  endtask
  task automatic test_arbitration();
    for (int i = 0; i < 3; i++) begin
      timSel = (i == 0);
      stopEn = 1'b0;
      irqCount = 0;
      partner.start_cond();
      fork
        partner.send_byte(i == 0 ? 8'h22 : 8'h00);
        begin
          repeat (12) @(negedge clk);
          if (i == 0) pulse(arbLost);
          else if (i == 1) pulse(chkStop);
          else pulse(chkRestart);
        end
      join
      repeat (6) @(negedge clk);
      check_num("arb irq 8th", i != 0, irqCount);
      partner.send_bit(1'b1);
      repeat (6) @(negedge clk);
      check_num("arb irq 9th", 1, irqCount);
      // restart attempt with the clock line held low, then a stop
      if (i == 2) begin
        stopEn = 1'b1;
        pulse(chkRestart);
      end
      partner.stop_cond();
      repeat (4) @(negedge clk);
      check_num("arb stop irq", (i == 2) ? 2 : 1, irqCount);
    end
  endtask
  task automatic test_start_wait();
    resvDis = 1'b0;
    partner.start_cond();
    partner.send_byte(8'h22);
    partner.send_bit(1'b1);
    repeat (8) @(negedge clk);
    pulse(startReq);
    repeat (START_FLAG_MAX_CLK - 1) @(negedge clk);
    check_bit("flag wait", 1'b0, flag);
    check_bit("sda held", 1'b1, sdaOe_n);
    partner.stop_cond();
    repeat (4) @(negedge clk);
    check_bit("sda after free", 1'b0, sdaOe_n);
    for (int i = 0; i < 300 && sclOe_n !== 1'b0; i++) @(negedge clk);
    check_bit("master wait", 1'b1, masterMode);
    for (int i = 0; i < 300 && sclOe_n !== 1'b1; i++) @(negedge clk);
    partner.stop_cond();
    repeat (4) @(negedge clk);
    check_bit("master wait stop", 1'b0, masterMode);
    resvDis = 1'b1;
  endtask
  task automatic test_start_free();
    resvDis = 1'b1;
    pulse(startReq);
    repeat (START_FLAG_MAX_CLK - 1) @(negedge clk);
    check_bit("flag free", 1'b0, flag);
    check_bit("sda drive", 1'b0, sdaOe_n);
    for (int i = 0; i < 300 && sclOe_n !== 1'b0; i++) @(negedge clk);
    check_bit("master", 1'b1, masterMode);
    for (int i = 0; i < 300 && sclOe_n !== 1'b1; i++) @(negedge clk);
    partner.stop_cond();
    repeat (4) @(negedge clk);
    check_bit("master after stop", 1'b0, masterMode);
  endtask
  task automatic test_start_reject();
    for (int i = 0; i < 2; i++) begin
      slaveEn = 1'b0;
      partner.start_cond();
      partner.send_byte(i == 0 ? 8'h22 : 8'hF0);
      partner.send_bit(1'b1);
      repeat (6) @(negedge clk);
      if (i == 1) pulse(leaveRel);
      repeat (2) @(negedge clk);
      check_bit("no role", 1'b0, slaveMode | masterMode);
      pulse(startReq);
      repeat (START_FLAG_MAX_CLK - 1) @(negedge clk);
      check_bit("flag reject", 1'b1, flag);
      check_bit("no sda drive", 1'b1, sdaOe_n);
      partner.stop_cond();
      slaveEn = 1'b1;
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    {reset_n, stopEn, timSel, resvDis, startReq, leaveRel, arbLost, chkStop, chkRestart} = '0;
    slaveEn = 1'b1;
    ownAddr = 7'h5A;
    repeat (2) @(posedge clk);
    @(negedge clk) reset_n = 1'b1;
    check_bit("irq reset", 1'b0, irq);
    check_bit("flag reset", 1'b0, flag);
    check_bit("oe reset", 1'b1, sdaOe_n & sclOe_n);
    check_bit("out reset", 1'b0, sdaOut | sclOut);
    repeat (4) @(negedge clk);
    test_wakeup();
    test_arbitration();
    test_start_free();
    test_start_reject();
    test_start_wait();
    wrap_up();
  end
  initial begin
    #2000000;
    n_errors++;
    wrap_up();
  end
endmodule
`default_nettype wire
